/* common/udt_pkg.sv */
// Register map, field positions and carrier types for the user device trap block
package udt_pkg;

  // Register indices on the configuration port
  localparam logic [1:0][7:0] UDT_BASE_IDX  = {8'hC8, 8'hC4};
  localparam logic [1:0][7:0] UDT_CTRL_IDX  = {8'hCE, 8'hCD};
  localparam logic [7:0]      UDT_SWINT_IDX = 8'hD0;
  localparam logic [7:0]      UDT_TTEST_IDX = 8'hEC;

  // Reset values
  localparam logic [7:0]  UDT_CTRL_RST  = 8'h00;
  localparam logic [31:0] UDT_BASE_RST  = 32'h0000_0000;
  localparam logic [7:0]  UDT_TTEST_RST = 8'h00;
  localparam logic [7:0]  UDT_RD_ZERO   = 8'h00;

  // Control field positions
  localparam int UDT_MAP_BIT   = 7;
  localparam int UDT_WR_EN_BIT = 6;
  localparam int UDT_RD_EN_BIT = 5;
  localparam int UDT_IO_MSK_W  = 5;
  localparam int UDT_MEM_MSK_W = 7;
  localparam int UDT_MEM_LSB   = 9;

  localparam int UDT_NDEV = 2;

  // Bus cycle observed by the trap comparators
  typedef struct packed {
    logic        valid;
    logic        is_mem;
    logic        is_write;
    logic [31:0] addr;
  } udt_cycle_type;

  // Configuration port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic [7:0] wdata;
  } udt_cfg_type;

  // Whole state of the block
  typedef struct packed {
    logic [UDT_NDEV-1:0][7:0]  ctrl;
    logic [UDT_NDEV-1:0][31:0] base;
    logic [7:0]                ttest;
    logic [7:0]                rdata;
    logic                      mgmt_int;
    logic [UDT_NDEV-1:0]       trap;
  } udt_state_type;

endpackage

/* hdl/udt_trap.sv */
// User device address trap control, base registers and software management interrupt
// Summary of operation
// - Control bit 7 selects I/O or memory space
// - I/O mode: bit 6 enables write tracking
// - I/O mode: bit 5 enables read tracking
// - I/O mode: bits 4:0 mask A[4:0]
// - Memory mode: bits 6:0 mask A[15:9]
// - Mask bit one ignores that address bit
// - Control registers read/write, reset to zero
// - Any write to trigger raises management interrupt
// - Trigger ignores data, reads back nothing
// - 32-bit base register compared per device
`timescale 1ns/1ps
`default_nettype none

module udt_trap
  import udt_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Configuration port
  input  wire udt_cfg_type         cfg,
  output logic [7:0]               cfg_rdata,
  // Observed bus cycles
  input  wire udt_cycle_type       cyc,
  // Events toward power management
  output logic [UDT_NDEV-1:0]      trap_pulse,
  output logic                     system_management_interrupt,
  // Timebase test value
  output logic [7:0]               timebase_test
);

  udt_state_type st_r;
  udt_state_type st_nxt;
  logic [UDT_NDEV-1:0] hit;

  // Per device comparators; the bus cycle is same-domain logic, no synchroniser
  genvar g;
  generate
    for (g = 0; g < UDT_NDEV; g++) begin : g_dev
      logic [7:0]  ctl;
      logic [31:0] diff;
      logic [31:0] io_care;
      logic [31:0] mem_care;
      logic        io_hit;
      logic        mem_hit;
      assign ctl      = st_r.ctrl[g];
      assign diff     = cyc.addr ^ st_r.base[g];
      assign io_care  = ~{27'h000_0000, ctl[UDT_IO_MSK_W-1:0]};
      assign mem_care = ~{16'h0000, ctl[UDT_MEM_MSK_W-1:0], 9'h1FF};
      assign io_hit   = cyc.valid && !cyc.is_mem && ((diff & io_care) == 32'h0000_0000)
                        && ((cyc.is_write && ctl[UDT_WR_EN_BIT])
                        || (!cyc.is_write && ctl[UDT_RD_EN_BIT]));
      // Memory mode tracks both directions; bits 6:0 are spent on the mask
      assign mem_hit  = cyc.valid && cyc.is_mem && ((diff & mem_care) == 32'h0000_0000);
      assign hit[g]   = ctl[UDT_MAP_BIT] ? mem_hit : io_hit;

      // Pulse checks look one cycle back, at the cycle that caused the pulse

      property p_space;
        @(posedge clk_sys) disable iff (!rst_n)
        st_r.trap[g] |-> $past(cyc.is_mem) == $past(st_r.ctrl[g][UDT_MAP_BIT]);
      endproperty
      a_space : assert property (p_space) else $error("trap in wrong space");

      property p_wr_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        st_r.trap[g] && !$past(cyc.is_mem) && $past(cyc.is_write)
        |-> $past(st_r.ctrl[g][UDT_WR_EN_BIT]);
      endproperty
      a_wr_gate : assert property (p_wr_gate) else $error("write trap while disabled");

      property p_rd_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        st_r.trap[g] && !$past(cyc.is_mem) && !$past(cyc.is_write)
        |-> $past(st_r.ctrl[g][UDT_RD_EN_BIT]);
      endproperty
      a_rd_gate : assert property (p_rd_gate) else $error("read trap while disabled");

      property p_io_mask;
        @(posedge clk_sys) disable iff (!rst_n)
        st_r.trap[g] && !$past(cyc.is_mem) |->
        ($past(cyc.addr[31:5]) == $past(st_r.base[g][31:5])) &&
        ((($past(cyc.addr[4:0]) ^ $past(st_r.base[g][4:0]))
          & ~$past(st_r.ctrl[g][4:0])) == 5'h00);
      endproperty
      a_io_mask : assert property (p_io_mask) else $error("io trap on mismatch");

      property p_mem_mask;
        @(posedge clk_sys) disable iff (!rst_n)
        st_r.trap[g] && $past(cyc.is_mem) |->
        ($past(cyc.addr[31:16]) == $past(st_r.base[g][31:16])) &&
        ((($past(cyc.addr[15:9]) ^ $past(st_r.base[g][15:9]))
          & ~$past(st_r.ctrl[g][6:0])) == 7'h00);
      endproperty
      a_mem_mask : assert property (p_mem_mask) else $error("mem trap on mismatch");

      // No mask bits set: any differing bit must block the pulse
      property p_exact;
        @(posedge clk_sys) disable iff (!rst_n)
        cyc.valid && st_r.ctrl[g] == 8'h60 && cyc.addr != st_r.base[g] |=> !st_r.trap[g];
      endproperty
      a_exact : assert property (p_exact) else $error("unmasked bit ignored");

      property p_event;
        @(posedge clk_sys) disable iff (!rst_n)
        hit[g] |=> st_r.trap[g] ##1 (st_r.trap[g] == $past(hit[g]));
      endproperty
      a_event : assert property (p_event) else $error("trap event missing");

      // Positive side: an enabled exact match must pulse
      property p_io_wr_hit;
        @(posedge clk_sys) disable iff (!rst_n)
        cyc.valid && !cyc.is_mem && cyc.is_write && !st_r.ctrl[g][UDT_MAP_BIT]
        && st_r.ctrl[g][UDT_WR_EN_BIT] && cyc.addr == st_r.base[g] |=> st_r.trap[g];
      endproperty
      a_io_wr_hit : assert property (p_io_wr_hit) else $error("io write not trapped");

      property p_io_rd_hit;
        @(posedge clk_sys) disable iff (!rst_n)
        cyc.valid && !cyc.is_mem && !cyc.is_write && !st_r.ctrl[g][UDT_MAP_BIT]
        && st_r.ctrl[g][UDT_RD_EN_BIT] && cyc.addr == st_r.base[g] |=> st_r.trap[g];
      endproperty
      a_io_rd_hit : assert property (p_io_rd_hit) else $error("io read not trapped");

      // Low nine address bits never take part in a memory compare
      property p_mem_hit;
        @(posedge clk_sys) disable iff (!rst_n)
        cyc.valid && cyc.is_mem && st_r.ctrl[g][UDT_MAP_BIT]
        && cyc.addr[31:9] == st_r.base[g][31:9] |=> st_r.trap[g];
      endproperty
      a_mem_hit : assert property (p_mem_hit) else $error("memory cycle not trapped");

      // Idle bus must never produce a pulse
      property p_trap_valid;
        @(posedge clk_sys) disable iff (!rst_n)
        st_r.trap[g] |-> $past(cyc.valid);
      endproperty
      a_trap_valid : assert property (p_trap_valid) else $error("trap without cycle");

      property p_ctrl_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !(cfg.wr && cfg.idx == UDT_CTRL_IDX[g]) |=> st_r.ctrl[g] == $past(st_r.ctrl[g]);
      endproperty
      a_ctrl_hold : assert property (p_ctrl_hold) else $error("control changed unasked");

      property p_ctrl_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        cfg.wr && cfg.idx == UDT_CTRL_IDX[g] |=> st_r.ctrl[g] == $past(cfg.wdata);
      endproperty
      a_ctrl_wr : assert property (p_ctrl_wr) else $error("control write lost");

      // Main scenarios
      c_mem_trap : cover property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.trap[g] && $past(cyc.is_mem));
      c_io_wr_trap : cover property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.trap[g] && !$past(cyc.is_mem) && $past(cyc.is_write));
    end
  endgenerate

  // Next state: register writes, read data, event pulses
  always_comb begin
    st_nxt       = st_r;
    st_nxt.mgmt_int = 1'b0;
    st_nxt.rdata = UDT_RD_ZERO;
    st_nxt.trap  = hit;
    for (int d = 0; d < UDT_NDEV; d++) begin
      if (cfg.wr && cfg.idx == UDT_CTRL_IDX[d]) begin
        st_nxt.ctrl[d] = cfg.wdata;
      end
      if (cfg.rd && cfg.idx == UDT_CTRL_IDX[d]) begin
        st_nxt.rdata = st_r.ctrl[d];
      end
      for (int b = 0; b < 4; b++) begin
        if (cfg.wr && cfg.idx == UDT_BASE_IDX[d] + 8'(b)) begin
          st_nxt.base[d][8*b +: 8] = cfg.wdata;
        end
        if (cfg.rd && cfg.idx == UDT_BASE_IDX[d] + 8'(b)) begin
          st_nxt.rdata = st_r.base[d][8*b +: 8];
        end
      end
    end
    // Data is irrelevant; only the strobe matters
    if (cfg.wr && cfg.idx == UDT_SWINT_IDX) begin
      st_nxt.mgmt_int = 1'b1;
    end
    // Test only; normal software leaves it alone
    if (cfg.wr && cfg.idx == UDT_TTEST_IDX) begin
      st_nxt.ttest = cfg.wdata;
    end
    if (cfg.rd && cfg.idx == UDT_TTEST_IDX) begin
      st_nxt.rdata = st_r.ttest;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r.ctrl  <= {UDT_NDEV{UDT_CTRL_RST}};
      st_r.base  <= {UDT_NDEV{UDT_BASE_RST}};
      st_r.ttest <= UDT_TTEST_RST;
      st_r.rdata <= UDT_RD_ZERO;
      st_r.mgmt_int <= 1'b0;
      st_r.trap  <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata                   = st_r.rdata;
  assign trap_pulse                  = st_r.trap;
  assign system_management_interrupt = st_r.mgmt_int;
  assign timebase_test               = st_r.ttest;

  // Register port checks; each strobe is a single cycle

  property p_swint;
    @(posedge clk_sys) disable iff (!rst_n)
    system_management_interrupt == $past(cfg.wr && cfg.idx == UDT_SWINT_IDX);
  endproperty
  a_swint : assert property (p_swint) else $error("management interrupt mismatch");

  property p_swint_rd;
    @(posedge clk_sys) disable iff (!rst_n)
    cfg.rd && cfg.idx == UDT_SWINT_IDX |=> cfg_rdata == UDT_RD_ZERO;
  endproperty
  a_swint_rd : assert property (p_swint_rd) else $error("trigger read not zero");

  // Bench leaves one idle cycle between accesses
  property p_ctrl_rb;
    @(posedge clk_sys) disable iff (!rst_n)
    cfg.wr && !cfg.rd && cfg.idx == UDT_CTRL_IDX[1]
    ##2 cfg.rd && !cfg.wr && cfg.idx == UDT_CTRL_IDX[1]
    |=> cfg_rdata == $past(cfg.wdata, 3);
  endproperty
  a_ctrl_rb : assert property (p_ctrl_rb) else $error("control readback wrong");

  property p_base_rb;
    @(posedge clk_sys) disable iff (!rst_n)
    cfg.wr && cfg.idx == UDT_BASE_IDX[1] |=> st_r.base[1][7:0] == $past(cfg.wdata);
  endproperty
  a_base_rb : assert property (p_base_rb) else $error("base byte not stored");

  property p_base_rb0;
    @(posedge clk_sys) disable iff (!rst_n)
    cfg.wr && cfg.idx == UDT_BASE_IDX[0] |=> st_r.base[0][7:0] == $past(cfg.wdata);
  endproperty
  a_base_rb0 : assert property (p_base_rb0) else $error("base byte not stored");

  // Read data must not linger, or a stale value looks like a register
  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!rst_n)
    !cfg.rd |=> cfg_rdata == UDT_RD_ZERO;
  endproperty
  a_rdata_idle : assert property (p_rdata_idle) else $error("read data not cleared");

  property p_ttest_wr;
    @(posedge clk_sys) disable iff (!rst_n)
    cfg.wr && cfg.idx == UDT_TTEST_IDX |=> timebase_test == $past(cfg.wdata);
  endproperty
  a_ttest_wr : assert property (p_ttest_wr) else $error("timer test write lost");

  property p_ttest_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    !(cfg.wr && cfg.idx == UDT_TTEST_IDX) |=> $stable(timebase_test);
  endproperty
  a_ttest_hold : assert property (p_ttest_hold) else $error("timer test changed");

  // Only a write strobe may raise the interrupt, never a read
  property p_swint_src;
    @(posedge clk_sys) disable iff (!rst_n)
    system_management_interrupt |-> $past(cfg.wr);
  endproperty
  a_swint_src : assert property (p_swint_src) else $error("interrupt without write");

  // Main scenarios
  c_swint : cover property (@(posedge clk_sys) disable iff (!rst_n)
    system_management_interrupt);
  c_both : cover property (@(posedge clk_sys) disable iff (!rst_n)
    &trap_pulse);

endmodule

`default_nettype wire

/* tb/udt_host.sv */
// Host model issuing configuration accesses and observed bus cycles
`timescale 1ns/1ps
`default_nettype none

module udt_host
  import udt_pkg::*;
(
  // Clock
  input  wire logic         clk_sys,
  // Requests toward the block
  output var udt_cfg_type   cfg,
  output var udt_cycle_type cyc
);
  initial begin
    cfg = '0;
    cyc = '0;
  end

  // One-cycle strobe; released lines show inverted values, not stale ones
  task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(negedge clk_sys);
    cfg = '{wr: w, rd: !w, idx: i, wdata: d};
    @(negedge clk_sys);
    cfg = '{wr: 1'b0, rd: 1'b0, idx: ~i, wdata: ~d};
  endtask

  task automatic bus(input logic m, input logic w, input logic [31:0] a);
    @(negedge clk_sys);
    cyc = '{valid: 1'b1, is_mem: m, is_write: w, addr: a};
    @(negedge clk_sys);
    cyc = '{valid: 1'b0, is_mem: ~m, is_write: ~w, addr: ~a};
  endtask
endmodule

`default_nettype wire

/* tb/udt_trap_tb.sv */
// Self-checking bench for the user device trap block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module udt_trap_tb
  import udt_pkg::*;
;
  logic                clk_sys;
  logic                rst_n;
  udt_cfg_type         cfg;
  udt_cycle_type       cyc;
  logic [7:0]          cfg_rdata;
  logic [7:0]          timebase_test;
  logic [UDT_NDEV-1:0] trap_pulse;
  logic                system_management_interrupt;
  int                  fail_count;
  int                  num_checks;
  logic [7:0]          dat [2] = '{8'h00, 8'hFF};

  udt_trap udt_trap_i (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg), .cfg_rdata(cfg_rdata),
    .cyc(cyc), .trap_pulse(trap_pulse), .timebase_test(timebase_test),
    .system_management_interrupt(system_management_interrupt));
  udt_host udt_host_i (.clk_sys(clk_sys), .cfg(cfg), .cyc(cyc));

  task automatic tally_and_finish;
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Read data is still standing at the release edge
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    udt_host_i.acc(1'b0, i, 8'h00);
    `CHK(cfg_rdata, e)
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    udt_host_i.acc(1'b1, i, d);
  endtask

  task automatic wb(input logic [7:0] i, input logic [31:0] v);
    for (int k = 0; k < 4; k++) begin
      wr(i + 8'(k), v[8*k +: 8]);
    end
  endtask

  task automatic trap(input logic m, input logic w, input logic [31:0] a, input logic [1:0] e);
    udt_host_i.bus(m, w, a);
    `CHK(trap_pulse, e)
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish;
  end

  initial begin
    fail_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(UDT_CTRL_IDX[0], 8'h00);
    rd(UDT_TTEST_IDX, 8'h00);
    wr(UDT_CTRL_IDX[1], 8'h5A);
    rd(UDT_CTRL_IDX[1], 8'h5A);
    wr(UDT_TTEST_IDX, 8'h3C);
    `CHK(timebase_test, 8'h3C)
    wr(8'hBF, 8'hFF);
    rd(8'hBF, 8'h00);
    foreach (dat[k]) begin
      wr(UDT_SWINT_IDX, dat[k]);
      `CHK(system_management_interrupt, 1'b1)
    end
    @(negedge clk_sys);
    `CHK(system_management_interrupt, 1'b0)
    rd(UDT_SWINT_IDX, 8'h00);
    // Device 2 in I/O space, low two address bits ignored
    wb(UDT_BASE_IDX[0], 32'h0000_0300);
    wr(UDT_CTRL_IDX[0], 8'h43);
    trap(1'b0, 1'b1, 32'h0000_0303, 2'b01);
    trap(1'b0, 1'b0, 32'h0000_0303, 2'b00);
    trap(1'b0, 1'b1, 32'h0000_0307, 2'b00);
    trap(1'b1, 1'b1, 32'h0000_0303, 2'b00);
    trap(1'b0, 1'b1, 32'h0001_0303, 2'b00);
    wr(UDT_CTRL_IDX[0], 8'h23);
    trap(1'b0, 1'b0, 32'h0000_0300, 2'b01);
    trap(1'b0, 1'b1, 32'h0000_0300, 2'b00);
    // Device 3 in memory space, A9 ignored
    wb(UDT_BASE_IDX[1], 32'h000A_0000);
    rd(UDT_BASE_IDX[1] + 8'h02, 8'h0A);
    wr(UDT_CTRL_IDX[1], 8'h81);
    trap(1'b1, 1'b0, 32'h000A_03FF, 2'b10);
    trap(1'b1, 1'b1, 32'h000A_0400, 2'b00);
    trap(1'b0, 1'b0, 32'h000A_0000, 2'b00);
    wr(UDT_CTRL_IDX[1], 8'hFF);
    trap(1'b1, 1'b1, 32'h000A_FE00, 2'b10);
    // Second reset in mid-run
    rst_n = 1'b0;
    @(negedge clk_sys);
    rst_n = 1'b1;
    rd(UDT_CTRL_IDX[1], 8'h00);
    tally_and_finish;
  end
endmodule

`default_nettype wire
